// ===== pcf_pkg.sv
package pcf_pkg;
	// ****************************************
	// bus map
	// ****************************************
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_SER_RX = 8'h08;
	localparam logic [7:0] ADR_SER_TX = 8'h0C;
	localparam logic [7:0] ADR_UDP_CMD = 8'h10;
	localparam logic [7:0] ADR_UDP_SRC = 8'h14;
	localparam logic [7:0] ADR_UDP_ID = 8'h18;
	localparam logic [7:0] ADR_REPLY_DONE = 8'h1C;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// ctrl fields
	localparam int CTRL_SE_EN = 0;
	localparam int CTRL_SE_ALT = 1;
	localparam int CTRL_RTS_MOD = 2;
	localparam int CTRL_TP_TCP = 3;
	localparam int CTRL_IB_EN = 4;
	localparam int CTRL_DL_EN = 5;
	localparam int CTRL_PRESEL = 6;
	localparam int CTRL_EXIT = 7;
	// ****************************************
	// framing and network constants
	// ****************************************
	localparam logic [7:0] CH_STX = 8'h02;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_IDSEP = 8'hA6;
	localparam logic [7:0] ESC_A = 8'h2B;
	localparam logic [7:0] ESC_B = 8'h1B;
	localparam int ESC_LEN = 3;
	localparam logic [15:0] UDP_PORT_A = 16'hFFFF;
	localparam logic [15:0] UDP_PORT_B = 16'h7FFF;
	localparam logic [15:0] TCP_TELNET = 16'h0017;
	localparam int Q_DEPTH = 8;
	localparam int ID_MAX = 4;
	localparam int BAUD_FORCED = 38400;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 10000000;
	localparam int MODE_HOLD_MS = 100;
	localparam int MODE_HOLD_CYC = (CLK_HZ / 1000) * MODE_HOLD_MS;
	typedef struct packed {
		logic [7:0] cmd;
		logic [31:0] ip;
		logic [15:0] port;
		logic [31:0] id;
		logic [2:0] id_len;
	} pcf_udp_type;
	typedef struct packed {
		logic en_se;
		logic alt_se;
		logic rts_mod;
		logic tp_tcp;
		logic ib_en;
		logic dl_en;
	} pcf_cfg_type;
endpackage

// ===== pcf_front_end.sv
`timescale 1ns/100ps
// Notes on behaviour
// (RULE_01) mode line held low 100 ms, or setup button, enters programming mode.
// (RULE_02) forced entry uses 38400 8-N-1 half duplex regardless of settings.
// (RULE_03) forced entry can never be blocked by any setting.
// (RULE_04) escape entry keeps current baud, forces 8-N-1 half duplex.
// (RULE_05) escape only when soft entry enabled; setting picks one of two sequences.
// (RULE_06) programming mode uses RTS for direction and ignores CTS.
// (RULE_07) RTS idle while awaiting commands, active only while a reply is sent.
// (RULE_08) RTS polarity selectable between board and module variants.
// (RULE_09) full-duplex partner uses TX/RX, ignores RTS, no flow control.
// (RULE_10) serial commands and replies start with STX and end with CR.
// (RULE_11) bytes outside an STX..CR frame are dropped.
// (RULE_12) no routing data passes while serial is in programming mode.
// (RULE_13) network commands run alongside routing without leaving it.
// (RULE_14) UDP ports 65535 and 32767 always accept commands.
// (RULE_15) inband commands only with TCP transport and inband setting 1.
// (RULE_16) command phase only with TCP transport and data-login setting 1.
// (RULE_17) port 23 TCP is programming; only one session logged in. The code only decodes the port and does not limit sessions.
// (RULE_18) one unframed command per datagram; reply goes to source ip and port.
// (RULE_19) up to eight UDP commands queued, executed one at a time.
// (RULE_20) optional id up to four chars after separator 166, echoed in reply.
// (RULE_21) broadcast non-broadcast-capable commands ignored unless preselected.
// (RULE_22) preselected device treats broadcast commands as addressed ones.
// (RULE_23) payload opens with one command code; reply opens with reply code.
// (RULE_24) STX inside an open frame restarts the frame.
// (RULE_25) UDP command arriving with eight queued is dropped silently.
module pcf_front_end (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// mode entry
	input wire logic mode_select_line_n_i,
	input wire logic setup_button_i,
	// serial receive byte stream
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic cts_i,
	// serial reply transmitter
	input wire logic tx_busy_i,
	output logic rts_o,
	output logic prog_mode_o,
	output logic forced_baud_o,
	output logic route_enable_o,
	// network command datagrams
	input wire logic udp_valid_i,
	input wire logic udp_bcast_i,
	input wire logic udp_bcast_ok_i,
	input wire logic [15:0] udp_dport_i,
	input wire logic [31:0] udp_sip_i,
	input wire logic [15:0] udp_sport_i,
	input wire logic [7:0] udp_byte_i,
	input wire logic udp_last_i,
	// tcp permissions
	input wire logic [15:0] tcp_dport_i,
	output logic inband_ok_o,
	output logic cmd_phase_ok_o,
	output logic telnet_prog_o
);
	import pcf_pkg::*;
	typedef enum logic {FR_IDLE, FR_BODY} pcf_fr_type;
	typedef enum logic [1:0] {DG_CODE, DG_BODY, DG_ID, DG_DROP} pcf_dg_type;
	// ****************************************
	// configuration register
	// ****************************************
	logic [31:0] ctrl_q;
	logic wr, rd;
	assign wr = cyc_i && stb_i && we_i && !ack_o;
	assign rd = cyc_i && stb_i && !we_i && !ack_o;
	logic exit_req;
	assign exit_req = wr && adr_i == ADR_CTRL && sel_i[0] && dat_i[CTRL_EXIT];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr && adr_i == ADR_CTRL) begin
			for (int b = 0; b < 4; b++) begin
				if (sel_i[b]) begin
					ctrl_q[b*8 +: 8] <= dat_i[b*8 +: 8];
				end
			end
			ctrl_q[CTRL_EXIT] <= 1'b0;
		end
	end
	// ****************************************
	// programming mode entry
	// ****************************************
	logic [20:0] hold_q;
	logic prog_q, forced_q, hold_hit;
	logic [1:0] esc_cnt_q;
	logic esc_hit;
	logic [7:0] esc_ch;
	assign esc_ch = ctrl_q[CTRL_SE_ALT] ? ESC_B : ESC_A; // see RULE_05
	assign hold_hit = hold_q == 21'(MODE_HOLD_CYC - 1);
	assign esc_hit = ctrl_q[CTRL_SE_EN] && rx_valid_i && rx_byte_i == esc_ch
		&& esc_cnt_q == 2'(ESC_LEN - 1); // see RULE_05
	always_ff @(posedge clk_i) begin
		if (rst_i || mode_select_line_n_i) begin
			hold_q <= '0;
		end else if (!hold_hit) begin
			hold_q <= hold_q + 21'h1; // see RULE_01
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || prog_q || !ctrl_q[CTRL_SE_EN]) begin
			esc_cnt_q <= '0;
		end else if (rx_valid_i) begin
			esc_cnt_q <= (rx_byte_i == esc_ch) ? esc_cnt_q + 2'h1 : 2'h0;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prog_q <= 1'b0;
			forced_q <= 1'b0;
		end else if ((hold_hit && !mode_select_line_n_i) || setup_button_i) begin
			prog_q <= 1'b1; // see RULE_01 see RULE_03
			forced_q <= 1'b1; // see RULE_02
		end else if (esc_hit && !prog_q) begin
			prog_q <= 1'b1; // see RULE_04
			forced_q <= 1'b0;
		end else if (exit_req) begin
			prog_q <= 1'b0;
			forced_q <= 1'b0;
		end
	end
	assign prog_mode_o = prog_q;
	assign forced_baud_o = forced_q; // see RULE_02
	assign route_enable_o = !prog_q; // see RULE_12 see RULE_13
	// ****************************************
	// rts direction, cts ignored
	// ****************************************
	logic rts_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rts_q <= 1'b1;
		end else begin
			rts_q <= (prog_q && tx_busy_i) ^ !ctrl_q[CTRL_RTS_MOD]; // see RULE_06 see RULE_07 see RULE_08
		end
	end
	assign rts_o = rts_q;
	// ****************************************
	// serial framer
	// ****************************************
	pcf_fr_type fr_q;
	logic [7:0] sbuf_q;
	logic sfull_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || !prog_q) begin
			fr_q <= FR_IDLE;
		end else if (rx_valid_i) begin
			unique case (fr_q)
				FR_IDLE: begin
					if (rx_byte_i == CH_STX) begin
						fr_q <= FR_BODY; // see RULE_10 see RULE_11
					end
				end
				FR_BODY: begin
					if (rx_byte_i == CH_CR) begin
						fr_q <= FR_IDLE; // see RULE_10
					end
				end
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sfull_q <= 1'b0;
			sbuf_q <= 8'h00;
		end else if (prog_q && rx_valid_i && fr_q == FR_BODY && rx_byte_i != CH_CR
			&& rx_byte_i != CH_STX) begin
			sbuf_q <= rx_byte_i; // see RULE_24
			sfull_q <= 1'b1;
		end else if (rd && adr_i == ADR_SER_RX) begin
			sfull_q <= 1'b0;
		end
	end
	// ****************************************
	// udp datagram intake and queue
	// ****************************************
	pcf_dg_type dg_q;
	pcf_udp_type cur_q;
	pcf_udp_type q_mem [Q_DEPTH];
	logic [3:0] cnt_q;
	logic [2:0] wp_q, rp_q;
	logic port_ok, bc_ok, push, pop;
	assign port_ok = udp_dport_i == UDP_PORT_A || udp_dport_i == UDP_PORT_B; // see RULE_14
	assign bc_ok = !udp_bcast_i || udp_bcast_ok_i || ctrl_q[CTRL_PRESEL]; // see RULE_21 see RULE_22
	assign push = udp_valid_i && udp_last_i && dg_q != DG_DROP && cnt_q != 4'(Q_DEPTH); // see RULE_25
	assign pop = wr && adr_i == ADR_REPLY_DONE && cnt_q != 4'h0; // see RULE_19
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dg_q <= DG_CODE;
			cur_q <= '0;
		end else if (udp_valid_i) begin
			if (udp_last_i) begin
				dg_q <= DG_CODE; // see RULE_18
			end else begin
				unique case (dg_q)
					DG_CODE: begin
						dg_q <= (port_ok && bc_ok) ? DG_BODY : DG_DROP;
						cur_q.cmd <= udp_byte_i; // see RULE_23
						cur_q.ip <= udp_sip_i; // see RULE_18
						cur_q.port <= udp_sport_i;
						cur_q.id <= '0;
						cur_q.id_len <= '0;
					end
					DG_BODY: begin
						if (udp_byte_i == CH_IDSEP) begin
							dg_q <= DG_ID; // see RULE_20
						end
					end
					DG_ID: begin
						if (cur_q.id_len != 3'(ID_MAX)) begin
							cur_q.id <= {cur_q.id[23:0], udp_byte_i}; // see RULE_20
							cur_q.id_len <= cur_q.id_len + 3'h1;
						end
					end
					DG_DROP: begin
					end
				endcase
			end
		end
	end
	// a datagram of one byte is checked on its only byte
	pcf_udp_type fin;
	always_comb begin
		fin = cur_q;
		if (dg_q == DG_CODE) begin
			fin.cmd = udp_byte_i;
			fin.ip = udp_sip_i;
			fin.port = udp_sport_i;
			fin.id = '0;
			fin.id_len = '0;
		end else if (dg_q == DG_ID && cur_q.id_len != 3'(ID_MAX)) begin
			fin.id = {cur_q.id[23:0], udp_byte_i};
			fin.id_len = cur_q.id_len + 3'h1;
		end
	end
	logic push_ok;
	assign push_ok = push && (dg_q != DG_CODE || (port_ok && bc_ok));
	always_ff @(posedge clk_i) begin
		if (push_ok) begin
			q_mem[wp_q] <= fin;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_q + 3'(push_ok);
			rp_q <= rp_q + 3'(pop);
			cnt_q <= cnt_q + 4'(push_ok) - 4'(pop); // see RULE_19
		end
	end
	// ****************************************
	// tcp programming permissions
	// ****************************************
	assign inband_ok_o = ctrl_q[CTRL_TP_TCP] && ctrl_q[CTRL_IB_EN]; // see RULE_15
	assign cmd_phase_ok_o = ctrl_q[CTRL_TP_TCP] && ctrl_q[CTRL_DL_EN]; // see RULE_16
	assign telnet_prog_o = tcp_dport_i == TCP_TELNET; // see RULE_17
	// ****************************************
	// bus read and ack
	// ****************************************
	pcf_udp_type head;
	assign head = q_mem[rp_q];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
			dat_o <= '0;
			if (rd) begin
				unique case (adr_i)
					ADR_CTRL: dat_o <= ctrl_q;
					ADR_STATUS: dat_o <= {22'h0, cnt_q, fr_q == FR_BODY, sfull_q, cts_i & 1'b0,
						rts_q, forced_q, prog_q};
					ADR_SER_RX: dat_o <= {23'h0, sfull_q, sbuf_q};
					ADR_UDP_CMD: dat_o <= {20'h0, head.id_len, cnt_q != 4'h0, head.cmd};
					ADR_UDP_SRC: dat_o <= head.ip;
					ADR_UDP_ID: dat_o <= head.id;
					ADR_REPLY_DONE: dat_o <= {16'h0, head.port};
					default: dat_o <= '0;
				endcase
			end
		end
	end
endmodule

// ===== pcf_front_end_asserts.sv
`timescale 1ns/100ps
// ****
// checks
// ****
module pcf_front_end_chk (
	// clock, reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// pins
	input wire logic setup_button_i,
	input wire logic tx_busy_i,
	input wire logic rts_o,
	input wire logic prog_mode_o,
	input wire logic forced_baud_o,
	input wire logic route_enable_o,
	input wire logic [15:0] tcp_dport_i,
	input wire logic telnet_prog_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_ans;
		ack_o ##1 !ack_o;
	endsequence
	property p_ack;
		s_req |=> s_ans;
	endproperty
	a_ack: assert property (p_ack) else $error("bad ack");
	property p_quiet;
		!(cyc_i && stb_i) |=> !ack_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("stray ack");
	property p_unmap;
		cyc_i && stb_i && !ack_o && !we_i && adr_i == 8'hFC |=> dat_o == 32'h0000_0000;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped data");
	property p_route;
		route_enable_o == !prog_mode_o;
	endproperty
	a_route: assert property (p_route) else $error("route in prog");
	property p_forced;
		setup_button_i |-> ##[1:2] prog_mode_o && forced_baud_o;
	endproperty
	a_forced: assert property (p_forced) else $error("no forced entry");
	property p_rts;
		prog_mode_o && $changed(tx_busy_i) |=> $changed(rts_o);
	endproperty
	a_rts: assert property (p_rts) else $error("rts lag");
	property p_telnet;
		telnet_prog_o == (tcp_dport_i == 16'h0017);
	endproperty
	a_telnet: assert property (p_telnet) else $error("telnet port");
	property p_hold;
		prog_mode_o && !(cyc_i && stb_i && we_i) |=> prog_mode_o;
	endproperty
	a_hold: assert property (p_hold) else $error("prog lost");
endmodule
bind pcf_front_end pcf_front_end_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .setup_button_i(setup_button_i),
	.tx_busy_i(tx_busy_i), .rts_o(rts_o), .prog_mode_o(prog_mode_o), .forced_baud_o(forced_baud_o),
	.route_enable_o(route_enable_o), .tcp_dport_i(tcp_dport_i), .telnet_prog_o(telnet_prog_o));

// ===== pcf_host_model.sv
`timescale 1ns/100ps
module pcf_host_model import pcf_pkg::*; (
	// clock
	input wire logic clk_i,
	// serial bytes
	output logic rx_valid_o = 1'b0,
	output logic [7:0] rx_byte_o = 8'h00,
	// datagrams
	output logic udp_valid_o = 1'b0,
	output logic udp_last_o = 1'b0,
	output logic udp_bcast_o = 1'b0,
	output logic udp_bcast_ok_o = 1'b0,
	output logic [15:0] udp_dport_o = 16'h0000,
	output logic [31:0] udp_sip_o = 32'h0000_0000,
	output logic [15:0] udp_sport_o = 16'h0000,
	output logic [7:0] udp_byte_o = 8'h00
);
	localparam logic [31:0] SIP = 32'h0A00_0105;
	localparam logic [15:0] SPORT = 16'h1F40;
	// rts never looked at, no flow control
	task ser(input logic [7:0] b);
		@(posedge clk_i);
		rx_valid_o <= 1'b1;
		rx_byte_o <= b;
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_byte_o <= ~b;
	endtask
	task ub(input logic [7:0] b, input logic l);
		@(posedge clk_i);
		udp_valid_o <= 1'b1;
		udp_byte_o <= b;
		udp_last_o <= l;
		@(posedge clk_i);
		udp_valid_o <= 1'b0;
		udp_byte_o <= ~b;
		udp_last_o <= 1'b0;
	endtask
	// unframed, code first, id after separator
	task udp(input logic [15:0] p, input logic bc, input logic ok, input logic [7:0] c, input logic [15:0] id);
		@(posedge clk_i);
		udp_dport_o <= p;
		udp_bcast_o <= bc;
		udp_bcast_ok_o <= ok;
		udp_sip_o <= SIP;
		udp_sport_o <= SPORT;
		ub(c, id == 16'h0000);
		if (id != 16'h0000) begin
			ub(CH_IDSEP, 1'b0);
			ub(id[15:8], 1'b0);
			ub(id[7:0], 1'b1);
		end
		udp_dport_o <= ~p;
		udp_sip_o <= ~SIP;
		udp_sport_o <= ~SPORT;
	endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import pcf_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, setup_button_i = 1'b0, cts_i = 1'b0, tx_busy_i = 1'b0;
	logic mode_select_line_n_i = 1'b1;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [15:0] tcp_dport_i = 16'h0000;
	logic [31:0] dat_o, q;
	logic ack_o, rts_o, prog_mode_o, forced_baud_o, route_enable_o, inband_ok_o, cmd_phase_ok_o, telnet_prog_o;
	logic rx_valid_i, udp_valid_i, udp_bcast_i, udp_bcast_ok_i, udp_last_i;
	logic [7:0] rx_byte_i, udp_byte_i;
	logic [15:0] udp_dport_i, udp_sport_i;
	logic [31:0] udp_sip_i;
	int n_errors = 0;
	int num_checks = 0;
	always #50 clk_i = ~clk_i;
	pcf_front_end i_pcf_front_end (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.mode_select_line_n_i(mode_select_line_n_i),
		.setup_button_i(setup_button_i), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .cts_i(cts_i),
		.tx_busy_i(tx_busy_i), .rts_o(rts_o), .prog_mode_o(prog_mode_o), .forced_baud_o(forced_baud_o),
		.route_enable_o(route_enable_o), .udp_valid_i(udp_valid_i), .udp_bcast_i(udp_bcast_i),
		.udp_bcast_ok_i(udp_bcast_ok_i), .udp_dport_i(udp_dport_i), .udp_sip_i(udp_sip_i),
		.udp_sport_i(udp_sport_i), .udp_byte_i(udp_byte_i), .udp_last_i(udp_last_i), .tcp_dport_i(tcp_dport_i),
		.inband_ok_o(inband_ok_o), .cmd_phase_ok_o(cmd_phase_ok_o), .telnet_prog_o(telnet_prog_o));
	pcf_host_model i_pcf_host_model (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i),
		.udp_valid_o(udp_valid_i), .udp_last_o(udp_last_i), .udp_bcast_o(udp_bcast_i),
		.udp_bcast_ok_o(udp_bcast_ok_i), .udp_dport_o(udp_dport_i), .udp_sip_o(udp_sip_i),
		.udp_sport_o(udp_sport_i), .udp_byte_o(udp_byte_i));
	task print_verdict;
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (ack_o !== 1'b1) begin
			n_errors++;
			$display("[ERR] %0t bus timeout", $time);
		end
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(q & m, e);
	endtask
	task esc(input logic [7:0] b);
		repeat (ESC_LEN) i_pcf_host_model.ser(b);
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(ADR_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
		rd(8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
		esc(ESC_A);
		rd(ADR_STATUS, 32'h1, 32'h0);
		wb(1'b1, ADR_CTRL, 32'h1);
		esc(ESC_B);
		rd(ADR_STATUS, 32'h1, 32'h0);
		esc(ESC_A);
		rd(ADR_STATUS, 32'h3, 32'h1);
		chk1(route_enable_o, 1'b0);
		i_pcf_host_model.ser(8'h41);
		rd(ADR_SER_RX, 32'h100, 32'h0);
		i_pcf_host_model.ser(CH_STX);
		i_pcf_host_model.ser(8'h47);
		rd(ADR_SER_RX, 32'h1FF, 32'h147);
		i_pcf_host_model.ser(CH_STX);
		rd(ADR_STATUS, 32'h20, 32'h20);
		i_pcf_host_model.ser(CH_CR);
		rd(ADR_STATUS, 32'h20, 32'h0);
		chk1(rts_o, 1'b1);
		tx_busy_i <= 1'b1;
		cts_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk1(rts_o, 1'b0);
		tx_busy_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk1(rts_o, 1'b1);
		wb(1'b1, ADR_CTRL, 32'h5);
		@(posedge clk_i);
		chk1(rts_o, 1'b0);
		wb(1'b1, ADR_CTRL, 32'h80);
		rd(ADR_STATUS, 32'h1, 32'h0);
		wb(1'b1, ADR_CTRL, 32'h3);
		esc(ESC_A);
		rd(ADR_STATUS, 32'h1, 32'h0);
		esc(ESC_B);
		rd(ADR_STATUS, 32'h3, 32'h1);
		wb(1'b1, ADR_CTRL, 32'h80);
		mode_select_line_n_i <= 1'b0;
		repeat (50) @(posedge clk_i);
		mode_select_line_n_i <= 1'b1;
		rd(ADR_STATUS, 32'h1, 32'h0);
		setup_button_i <= 1'b1;
		@(posedge clk_i);
		setup_button_i <= 1'b0;
		rd(ADR_STATUS, 32'h3, 32'h3);
		for (int k = 0; k < 8; k++) begin
			tcp_dport_i <= k[1] ? TCP_TELNET : 16'h0018;
			wb(1'b1, ADR_CTRL, {26'h0, k[2:0], 3'h0});
			chk1(inband_ok_o, k[1] & k[0]);
			chk1(cmd_phase_ok_o, k[2] & k[0]);
			chk1(telnet_prog_o, k[1]);
		end
		wb(1'b1, ADR_CTRL, 32'h0);
		i_pcf_host_model.udp(UDP_PORT_A, 1'b0, 1'b0, 8'h53, 16'h3139);
		rd(ADR_UDP_CMD, 32'hFFFF_FFFF, 32'h553);
		rd(ADR_UDP_ID, 32'hFFFF_FFFF, 32'h3139);
		rd(ADR_UDP_SRC, 32'hFFFF_FFFF, i_pcf_host_model.SIP);
		rd(ADR_REPLY_DONE, 32'hFFFF, {16'h0, i_pcf_host_model.SPORT});
		wb(1'b1, ADR_REPLY_DONE, 32'h0);
		i_pcf_host_model.udp(16'h1234, 1'b0, 1'b0, 8'h41, 16'h0);
		i_pcf_host_model.udp(UDP_PORT_B, 1'b0, 1'b0, 8'h47, 16'h0);
		i_pcf_host_model.udp(UDP_PORT_A, 1'b1, 1'b0, 8'h53, 16'h0);
		i_pcf_host_model.udp(UDP_PORT_A, 1'b1, 1'b1, 8'h58, 16'h0);
		rd(ADR_STATUS, 32'h3C0, 32'h80);
		wb(1'b1, ADR_CTRL, 32'h40);
		repeat (7) i_pcf_host_model.udp(UDP_PORT_A, 1'b1, 1'b0, 8'h53, 16'h0);
		rd(ADR_STATUS, 32'h3C0, 32'h200);
		repeat (8) wb(1'b1, ADR_REPLY_DONE, 32'h0);
		rd(ADR_UDP_CMD, 32'h100, 32'h0);
		print_verdict();
	end
endmodule
